// ---- sac_map.svh ----
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ==========================================================================
// conversion clock numbering, counted from the first conversion clock
// ==========================================================================
`define SAC_CNT_IDLE      4'h0
`define SAC_CLK_FIRST     4'h1
`define SAC_CLK_SAMPLE    4'h3
`define SAC_CLK_MSB       4'h4
`define SAC_CLK_REF_OPEN  4'hD
`define SAC_CLK_LSB       4'hD
`define SAC_CLK_LAST      4'hE
`define SAC_CNT_STEP      4'h1

// ==========================================================================
// reset and drive values
// ==========================================================================
`define SAC_RST_BIT       1'b0
`define SAC_RST_TRACK     1'b1
`define SAC_RST_REFWIN    1'b1
`define SAC_DRIVE_LOW     1'b0
`define SAC_OE_ON         1'b1
`define SAC_OE_OFF        1'b0

`endif

// ---- sac_pkg.sv ----
// ==========================================================================
// sequencer types
// ==========================================================================
package sac_pkg;

   // gray codes along idle -> conv -> gap -> conv
   typedef enum logic [1:0] {
      sac_st_idle = 2'b00,
      sac_st_conv = 2'b01,
      sac_st_gap  = 2'b11
   } sac_state_t;

   // how the last cycle ended, judged from start-convert alone
   typedef enum logic [1:0] {
      sac_mode_none   = 2'b00,
      sac_mode_single = 2'b01,
      sac_mode_sync   = 2'b10,
      sac_mode_free   = 2'b11
   } sac_mode_t;

endpackage : sac_pkg

// ---- sac_seq.sv ----
`timescale 1ns/100ps
`include "sac_map.svh"
// Behaviour
// - low start begins conversion next rising edge
// - msb driven after falling edge of clock four
// - every conversion lasts exactly fourteen clocks
// - start high at fall fourteen floats, idles
// - synchronized: pin driven low between conversions
// - start held low gives back-to-back conversions
// - free run: pin driven low between cycles
// - track from clock fourteen, hold fall three
// - mode chosen only by start-convert behaviour
// - start low launches cycle, enables driver
// - result shifted out on one tristate pin
// - ten-bit successive approximation, msb first
// - pin driven low until first result bit
// - straight binary result coding
module sac_seq #(
   parameter int unsigned RES_W = 10
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // converter clock and start, synchronous to mclk
   input  wire logic               conv_clk,
   input  wire logic               start_convert_n,
   // successive approximation loop
   input  wire logic               cmp_above,
   output logic [RES_W-1:0]        sar_trial,
   output logic                    track,
   output logic                    ref_window,
   // serial data pin
   output logic                    data_out,
   output logic                    data_oe,
   // status
   output logic [RES_W-1:0]        result,
   output logic                    result_valid,
   output logic [3:0]              conv_index,
   output sac_pkg::sac_mode_t      mode
);
   import sac_pkg::*;

   // =======================================================================
   // helpers
   // =======================================================================
   function automatic logic sac_is_bit_clk(input logic [3:0] cnt);
      return (cnt >= `SAC_CLK_MSB) && (cnt <= `SAC_CLK_LSB);
   endfunction : sac_is_bit_clk

   // msb at the msb clock, then one bit lower per clock
   function automatic logic [RES_W-1:0] sac_bit_mask(input logic [3:0] cnt);
      logic [3:0] idx;
      idx = 4'(RES_W - 1) - (cnt - `SAC_CLK_MSB);
      return {{(RES_W-1){1'b0}}, 1'b1} << idx;
   endfunction : sac_bit_mask

   // =======================================================================
   // state
   // =======================================================================
   sac_state_t         state_r;
   sac_state_t         state_nxt;
   logic               clk_q_r;
   logic [3:0]         cnt_r;
   logic [3:0]         cnt_nxt;
   logic [RES_W-1:0]   acc_r;
   logic [RES_W-1:0]   acc_nxt;
   logic [RES_W-1:0]   trial_r;
   logic [RES_W-1:0]   trial_nxt;
   logic [RES_W-1:0]   result_r;
   logic               valid_r;
   logic               dout_r;
   logic               dout_nxt;
   logic               oe_r;
   logic               oe_nxt;
   logic               track_r;
   logic               track_nxt;
   logic               refwin_r;
   logic               refwin_nxt;
   logic               rose_r;
   logic               rose_nxt;
   sac_mode_t          mode_r;
   sac_mode_t          mode_nxt;

   // =======================================================================
   // clock edges of the converter clock
   // =======================================================================
   // the converter clock is only sampled, so each of its edges is seen
   // one mclk late; conv_clk must stay well below mclk/2
   wire        clk_rise   = conv_clk & ~clk_q_r;
   wire        clk_fall   = ~conv_clk & clk_q_r;
   wire        start_low  = ~start_convert_n;
   wire        in_idle    = (state_r == sac_st_idle);
   wire        in_conv    = (state_r == sac_st_conv);
   wire        in_gap     = (state_r == sac_st_gap);
   wire [3:0]  cnt_step   = cnt_r + `SAC_CNT_STEP;

   // =======================================================================
   // event decode
   // =======================================================================
   wire launch_idle = clk_rise & in_idle & start_low;
   wire launch_gap  = clk_rise & in_gap;
   wire launch      = launch_idle | launch_gap;
   wire conv_rise   = clk_rise & in_conv & (cnt_r < `SAC_CLK_LAST);

   // every falling-edge event belongs to a running conversion
   wire conv_fall   = clk_fall & in_conv;
   wire last_fall   = conv_fall & (cnt_r == `SAC_CLK_LAST);
   wire sample_fall = conv_fall & (cnt_r == `SAC_CLK_SAMPLE);
   wire ref_fall    = conv_fall & (cnt_r == `SAC_CLK_REF_OPEN);
   wire bit_rise    = conv_rise & sac_is_bit_clk(cnt_step);
   wire bit_fall    = conv_fall & sac_is_bit_clk(cnt_r);
   wire lsb_end     = conv_rise & (cnt_r == `SAC_CLK_LSB);
   wire stay_sel    = last_fall & start_low;
   wire go_idle     = last_fall & ~start_low;

   wire [RES_W-1:0] fall_mask = sac_bit_mask(cnt_r);
   wire [RES_W-1:0] rise_mask = sac_bit_mask(cnt_step);

   // =======================================================================
   // next state
   // =======================================================================
   // a cycle is launched only from idle or gap, so a late start edge inside
   // a conversion can never shorten it
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         sac_st_idle: begin
            if (launch_idle) begin
               state_nxt = sac_st_conv;
            end
         end
         sac_st_conv: begin
            if (stay_sel) begin
               state_nxt = sac_st_gap;
            end else if (go_idle) begin
               state_nxt = sac_st_idle;
            end
         end
         sac_st_gap: begin
            if (launch_gap) begin
               state_nxt = sac_st_conv;
            end
         end
         // the spare code is unreachable; falling back to idle keeps a
         // disturbed state register from locking the sequencer
         default: begin
            state_nxt = sac_st_idle;
         end
      endcase
   end

   assign cnt_nxt   = launch    ? `SAC_CLK_FIRST :
                      conv_rise ? cnt_step :
                      go_idle   ? `SAC_CNT_IDLE :
                                  cnt_r;

   // =======================================================================
   // successive approximation
   // =======================================================================
   // comparator high means input above trial: straight binary code
   assign acc_nxt   = launch   ? {RES_W{1'b0}} :
                      bit_fall ? (cmp_above ? (acc_r | fall_mask)
                                            : (acc_r & ~fall_mask)) :
                                 acc_r;

   assign trial_nxt = launch   ? {RES_W{1'b0}} :
                      bit_rise ? (acc_r | rise_mask) :
                                 trial_r;

   // =======================================================================
   // serial pin
   // =======================================================================
   // the lsb is cut at the rising edge of the last clock, so it stands
   // only for the low half of clock thirteen
   assign dout_nxt  = launch   ? `SAC_DRIVE_LOW :
                      bit_fall ? cmp_above :
                      lsb_end  ? `SAC_DRIVE_LOW :
                                 dout_r;

   assign oe_nxt    = launch   ? `SAC_OE_ON :
                      go_idle  ? `SAC_OE_OFF :
                                 oe_r;

   // =======================================================================
   // track, hold and reference window
   // =======================================================================
   assign track_nxt  = sample_fall ? 1'b0 :
                       lsb_end     ? 1'b1 :
                                     track_r;

   assign refwin_nxt = sample_fall ? 1'b0 :
                       ref_fall    ? 1'b1 :
                                     refwin_r;

   // =======================================================================
   // mode, judged from start-convert only
   // =======================================================================
   // one flag per cycle: start seen high at any point while converting
   wire seen_high = in_conv & ~start_low;

   assign rose_nxt  = launch    ? 1'b0 :
                      seen_high ? 1'b1 :
                                  rose_r;

   assign mode_nxt  = go_idle  ? sac_mode_single :
                      stay_sel ? (rose_r ? sac_mode_sync
                                         : sac_mode_free) :
                                 mode_r;

   // =======================================================================
   // registers
   // =======================================================================
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= sac_st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_q_r <= `SAC_RST_BIT;
         cnt_r   <= `SAC_CNT_IDLE;
      end else begin
         clk_q_r <= conv_clk;
         cnt_r   <= cnt_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_r   <= {RES_W{1'b0}};
         trial_r <= {RES_W{1'b0}};
      end else begin
         acc_r   <= acc_nxt;
         trial_r <= trial_nxt;
      end
   end

   // result word taken when the lsb is complete
   always_ff @(posedge mclk) begin
      if (rst) begin
         result_r <= {RES_W{1'b0}};
         valid_r  <= `SAC_RST_BIT;
      end else begin
         valid_r  <= lsb_end;
         if (lsb_end) begin
            result_r <= acc_r;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dout_r <= `SAC_DRIVE_LOW;
         oe_r   <= `SAC_OE_OFF;
      end else begin
         dout_r <= dout_nxt;
         oe_r   <= oe_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         track_r  <= `SAC_RST_TRACK;
         refwin_r <= `SAC_RST_REFWIN;
      end else begin
         track_r  <= track_nxt;
         refwin_r <= refwin_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rose_r <= `SAC_RST_BIT;
         mode_r <= sac_mode_none;
      end else begin
         rose_r <= rose_nxt;
         mode_r <= mode_nxt;
      end
   end

   // =======================================================================
   // outputs
   // =======================================================================
   assign sar_trial    = trial_r;
   assign track        = track_r;
   assign ref_window   = refwin_r;
   assign data_out     = dout_r;
   assign data_oe      = oe_r;
   assign result       = result_r;
   assign result_valid = valid_r;
   assign conv_index   = cnt_r;
   assign mode         = mode_r;

endmodule : sac_seq

// ---- sac_seq_properties.sv ----
`timescale 1ns/100ps
// ==========
// sequencer port checker
// ==========
module sac_seq_properties
   import sac_pkg::*;
#(
   parameter int unsigned RES_W = 10
) (
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               conv_clk,
   input wire logic               start_convert_n,
   input wire logic               cmp_above,
   input wire logic [RES_W-1:0]   sar_trial,
   input wire logic               track,
   input wire logic               ref_window,
   input wire logic               data_out,
   input wire logic               data_oe,
   input wire logic [RES_W-1:0]   result,
   input wire logic               result_valid,
   input wire logic [3:0]         conv_index,
   input wire sac_pkg::sac_mode_t mode
);
   // edge detector mirrors the design: previous level reads 0 after reset
   logic clk_r;
   always_ff @(posedge mclk) begin
      if (rst) clk_r <= 1'b0;
      else clk_r <= conv_clk;
   end
   wire rise_w = conv_clk && !clk_r;
   wire fall_w = !conv_clk && clk_r;
   wire busy_w = conv_index >= 4'h1 && conv_index <= 4'hD;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_end_high;
      conv_index == 4'hE && fall_w && start_convert_n;
   endsequence
   sequence s_idle_out;
      !data_oe && conv_index == 4'h0 && mode == sac_mode_single;
   endsequence
   a_launch_drive: assert property (conv_index == 4'h0 && rise_w
      && !start_convert_n |=> conv_index == 4'h1 && data_oe && !data_out)
      else $error("launch wrong");
   a_index_step: assert property (busy_w && rise_w
      |=> conv_index == $past(conv_index) + 4'h1) else $error("index step");
   a_single_end: assert property (s_end_high |=> s_idle_out)
      else $error("single end");
   a_gap_drive: assert property (conv_index == 4'hE && fall_w
      && !start_convert_n |=> data_oe && !data_out) else $error("gap drive");
   a_msb_time: assert property (conv_index == 4'h4 && fall_w
      |=> data_out == $past(cmp_above)) else $error("msb late");
   a_sample_hold: assert property (conv_index == 4'h3 && fall_w
      |=> !track && !ref_window) else $error("hold late");
   a_track_again: assert property (conv_index == 4'hD && rise_w
      |=> track && conv_index == 4'hE && result_valid)
      else $error("track late");
   a_valid_pulse: assert property (result_valid
      |-> conv_index == 4'hE ##1 !result_valid) else $error("valid pulse");
   a_idle_float: assert property (conv_index == 4'h0 |-> !data_oe)
      else $error("idle drives");
   a_drive_conv: assert property (busy_w |-> data_oe)
      else $error("pin floats");
   a_trial_msb: assert property (conv_index == 4'h3 && rise_w
      |=> sar_trial == 10'h200) else $error("trial msb");
   a_result_hold: assert property (!result_valid
      |-> $stable(result)) else $error("result moved");
   a_free_relaunch: assert property (conv_index == 4'hE && rise_w
      |=> conv_index == 4'h1 && data_oe && !data_out)
      else $error("no relaunch");
   a_ref_open: assert property (conv_index == 4'hD && fall_w
      |=> ref_window) else $error("ref window shut");
endmodule : sac_seq_properties

// ---- sac_host_model.sv ----
`timescale 1ns/100ps
// ==========
// host: converter clock, comparator, serial capture
// ==========
module sac_host_model #(
   parameter int unsigned HALF = 3
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // analog level given as a code
   input  wire logic [9:0] ain,
   // converter side
   input  wire logic [9:0] sar_trial,
   input  wire logic [3:0] conv_index,
   input  wire logic       data_out,
   input  wire logic       data_oe,
   output logic            conv_clk,
   output logic            cmp_above,
   output logic [9:0]      rx_word
);
   int unsigned ph;
   // clock runs always, so it never stops inside a cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         ph <= 0;
         conv_clk <= 1'b0;
         rx_word <= 10'h000;
      end else if (ph == HALF - 1) begin
         ph <= 0;
         conv_clk <= ~conv_clk;
         // latch late in the low phase, well clear of the falling edge
         if (!conv_clk && data_oe && conv_index >= 4 && conv_index <= 13)
            rx_word <= {rx_word[8:0], data_out};
      end else begin
         ph <= ph + 1;
      end
   end
   assign cmp_above = (ain >= sar_trial);
endmodule : sac_host_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   import sac_pkg::*;
   logic mclk, rst, start_convert_n, conv_clk, cmp_above, track, ref_window;
   logic data_out, data_oe, result_valid;
   logic [9:0] ain, a, sar_trial, result, rx_word;
   logic [3:0] conv_index;
   sac_mode_t  mode;
   int num_errors, n_checks;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   sac_seq #(.RES_W(10)) dut (.mclk(mclk), .rst(rst), .conv_clk(conv_clk),
      .start_convert_n(start_convert_n), .cmp_above(cmp_above),
      .sar_trial(sar_trial), .track(track), .ref_window(ref_window),
      .data_out(data_out), .data_oe(data_oe), .result(result),
      .result_valid(result_valid), .conv_index(conv_index), .mode(mode));
   sac_host_model u_host (.mclk(mclk), .rst(rst), .ain(ain),
      .sar_trial(sar_trial), .conv_index(conv_index), .data_out(data_out),
      .data_oe(data_oe), .conv_clk(conv_clk), .cmp_above(cmp_above),
      .rx_word(rx_word));
   // ==========
   // expectation and helpers
   // ==========
   function automatic logic [9:0] sar_exp(input logic [9:0] v);
      logic [9:0] w;
      w = 10'h000;
      for (int b = 9; b >= 0; b--)
         if (v >= (w | (10'h001 << b))) w = w | (10'h001 << b);
      return w;
   endfunction : sar_exp
   task automatic summarize;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   // sel 0 waits for an index, sel 1 for the result pulse
   task automatic wait_ev(input int sel, input logic [3:0] k);
      for (int i = 0; i < 3000; i++) begin
         @(posedge mclk);
         #1;
         if (sel == 0 ? conv_index === k : result_valid === 1'b1) return;
      end
      num_errors++;
      summarize();
   endtask : wait_ev
   // ==========
   // main sequence
   // ==========
   initial begin
      rst = 1'b1;
      start_convert_n = 1'b1;
      ain = 10'h000;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(58));
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK(data_oe, 1'b0)
      `CHK(ref_window, 1'b1)
      `CHK(track, 1'b1)
      `CHK(mode, sac_mode_none)
      // single shots, both code extremes first
      for (int n = 0; n < 6; n++) begin
         a = (n == 0) ? 10'h000 : (n == 1) ? 10'h3FF : 10'($urandom);
         @(posedge mclk);
         ain <= a;
         start_convert_n <= 1'b0;
         wait_ev(0, 4'h2);
         @(posedge mclk);
         start_convert_n <= 1'b1;
         wait_ev(1, 4'h0);
         `CHK(result, sar_exp(a))
         `CHK(rx_word, sar_exp(a))
         wait_ev(0, 4'h0);
         `CHK(mode, sac_mode_single)
      end
      // free run, then a relower inside the cycle, then a single end
      @(posedge mclk);
      start_convert_n <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         a = 10'($urandom);
         @(posedge mclk);
         ain <= a;
         wait_ev(0, 4'h2);
         if (n == 1) `CHK(mode, sac_mode_free)
         if (n == 3) `CHK(mode, sac_mode_sync)
         if (n >= 2) begin
            @(posedge mclk);
            start_convert_n <= 1'b1;
         end
         if (n == 2) begin
            wait_ev(0, 4'h5);
            @(posedge mclk);
            start_convert_n <= 1'b0;
         end
         wait_ev(1, 4'h0);
         `CHK(result, sar_exp(a))
         `CHK(rx_word, sar_exp(a))
      end
      wait_ev(0, 4'h0);
      `CHK(data_oe, 1'b0)
      summarize();
   end
endmodule : tb_top
bind sac_seq sac_seq_properties #(.RES_W(RES_W)) u_props (.mclk(mclk),
   .rst(rst), .conv_clk(conv_clk), .start_convert_n(start_convert_n),
   .cmp_above(cmp_above), .sar_trial(sar_trial), .track(track),
   .ref_window(ref_window), .data_out(data_out), .data_oe(data_oe),
   .result(result), .result_valid(result_valid), .conv_index(conv_index),
   .mode(mode));
